// >>> logic/delay_counter.sv
// one-shot cycle counter giving a single pulse after a loaded number of cycles
module delay_counter
   import meter_init_pkg::*;
#(
   parameter int CNT_W = 24
)
(
   // clock and reset
   input  wire logic             mclk_i,
   input  wire logic             srst_i,
   // control
   input  wire logic             load_i,
   input  wire logic [CNT_W-1:0] cycles_i,
   output logic                  expired_o
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             run;
   } dly_s;

   dly_s r, n;

   if (CNT_W < 2) $error("delay_counter: CNT_W too small");

   // pulse lands exactly cycles_i - 1 edges after the load edge
   always_comb
   begin
      n = r;
      if (load_i)
      begin
         n.cnt = cycles_i - {{(CNT_W-1){1'b0}}, 1'b1};
         n.run = 1'b1;
      end
      else if (r.run)
      begin
         if (r.cnt == '0)
            n.run = 1'b0;
         else
            n.cnt = r.cnt - {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
         r <= '0;
      else
         r <= n;
   end

   assign expired_o = r.run && (r.cnt == '0);

endmodule : delay_counter

// >>> logic/meter_init_ctrl.sv
// start-up, power-mode and reset controller for a three-phase metering ic
module meter_init_ctrl
   import meter_init_pkg::*;
#(
   parameter int          AW               = 8,
   parameter int          CNT_W            = 24,
   parameter int unsigned POWER_UP_CYCLES  = POWERUP_CYC,
   parameter int unsigned RESET_LOW_CYCLES = RESET_CYC,
   parameter int          SER_HALF         = SER_HALF_CYC
)
(
   // clock and reset
   input  wire logic          mclk_i,
   input  wire logic          srst_i,
   // axi4-lite write address and data
   input  wire logic [AW-1:0] s_axi_awaddr_i,
   input  wire logic          s_axi_awvalid_i,
   output logic               s_axi_awready_o,
   input  wire logic [31:0]   s_axi_wdata_i,
   input  wire logic [3:0]    s_axi_wstrb_i,
   input  wire logic          s_axi_wvalid_i,
   output logic               s_axi_wready_o,
   // axi4-lite write response
   output logic [1:0]         s_axi_bresp_o,
   output logic               s_axi_bvalid_o,
   input  wire logic          s_axi_bready_i,
   // axi4-lite read
   input  wire logic [AW-1:0] s_axi_araddr_i,
   input  wire logic          s_axi_arvalid_i,
   output logic               s_axi_arready_o,
   output logic [31:0]        s_axi_rdata_o,
   output logic [1:0]         s_axi_rresp_o,
   output logic               s_axi_rvalid_o,
   input  wire logic          s_axi_rready_i,
   // metering ic power and reset pins
   output logic               power_mode_select_a_o,
   output logic               power_mode_select_b_o,
   output logic               ic_reset_n_o,
   // metering ic spi pins
   output logic               spi_cs_n_o,
   output logic               spi_sclk_o,
   output logic               spi_mosi_o,
   // metering ic i2c pins, open drain
   output logic               i2c_scl_o,
   output logic               i2c_scl_oe_o,
   output logic               i2c_sda_o,
   output logic               i2c_sda_oe_o,
   input  wire logic          i2c_sda_i,
   // board strap
   input  wire logic          takeover_select_input_i
);

   ////////////////////////////////////////////////////////////////////////////
   // types and state

   typedef enum logic [2:0] {Q_IDLE, Q_PWR_WAIT, Q_XFER, Q_XWAIT, Q_RST_LOW} seq_e;

   typedef struct packed {
      logic [15:0] addr;
      logic [31:0] data;
      logic [2:0]  nbytes;
   } frame_s;

   typedef struct packed {
      seq_e          st;
      logic [2:0]    step;
      logic          i2c;
      logic          sampled;
      logic          take;
      logic          pm_normal;
      logic          init_done;
      logic          rst_low;
      logic          done;
      logic          fail;
      logic          tload;
      logic          xstart;
      logic          aw_got;
      logic [AW-1:0] aw_addr;
      logic          w_got;
      logic [31:0]   w_data;
      logic [3:0]    w_strb;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          rvalid;
      logic [31:0]   rdata;
      logic [1:0]    rresp;
   } ctl_s;

   ctl_s             r, n;
   frame_s           frame;
   logic             eng_done;
   logic             eng_fail;
   logic             eng_sclk;
   logic             eng_dout;
   logic             eng_cs_n;
   logic             t_expired;
   logic [CNT_W-1:0] t_cycles;
   logic             idle_ok;
   logic [31:0]      status_w;

   if (AW < 8) $error("meter_init_ctrl: AW must be at least 8");
   if (CNT_W > 31 || POWER_UP_CYCLES >= (32'h1 << CNT_W)
       || RESET_LOW_CYCLES >= (32'h1 << CNT_W) || POWER_UP_CYCLES < 1
       || RESET_LOW_CYCLES < 1)
      $error("meter_init_ctrl: delay counts do not fit CNT_W");

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // word decode shared by the read and the write path
   function automatic logic reg_hit(input logic [AW-1:0] a, input logic [7:0] ofs);
      reg_hit = ({a[AW-1:2], 2'b00} == AW'(ofs));   // offsets are word aligned
   endfunction : reg_hit

   // frame written at each step of the normal-mode entry
   function automatic frame_s step_frame(input logic [2:0] step);
      frame_s f;
      f = '{addr: PORT_ACT_ADDR, data: 32'h0000_0000, nbytes: 3'h1};
      case (step)
         3'h3:    f = '{addr: SEC_CFG_ADDR, data: PORT_LOCK_VAL, nbytes: 3'h1};
         3'h4:    f = '{addr: INTCOEF_ADDR, data: INTCOEF_VAL, nbytes: 3'h4};
         3'h5:    f = '{addr: RUN_ADDR, data: RUN_VAL, nbytes: 3'h2};
         default: f = '{addr: PORT_ACT_ADDR, data: 32'h0000_0000, nbytes: 3'h1};
      endcase
      step_frame = f;
   endfunction : step_frame

   assign frame   = step_frame(r.step);
   // commands are refused until the strap is caught, in takeover, or while busy
   assign idle_ok = (r.st == Q_IDLE) && r.sampled && !r.take;

   // status word seen by software
   always_comb
   begin
      status_w                = 32'h0000_0000;
      status_w[ST_BUSY_BIT]   = (r.st != Q_IDLE);
      status_w[ST_DONE_BIT]   = r.done;
      status_w[ST_FAIL_BIT]   = r.fail;
      status_w[ST_NORMAL_BIT] = r.pm_normal;
      status_w[ST_INIT_BIT]   = r.init_done;
      status_w[ST_TAKE_BIT]   = r.take;
      status_w[ST_STEP_LSB +: 3] = r.step;
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus slave and sequencer

   assign s_axi_awready_o = !r.aw_got && !r.bvalid;
   assign s_axi_wready_o  = !r.w_got && !r.bvalid;
   assign s_axi_arready_o = !r.rvalid;

   always_comb
   begin
      n        = r;
      n.tload  = 1'b0;
      n.xstart = 1'b0;

      // strap is caught on the first edge after reset and then frozen
      if (!r.sampled)
      begin
         n.sampled = 1'b1;
         n.take    = takeover_select_input_i;
      end

      // address and data may come in either order
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
         n.aw_got  = 1'b1;
         n.aw_addr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
         n.w_got  = 1'b1;
         n.w_data = s_axi_wdata_i;
         n.w_strb = s_axi_wstrb_i;
      end
      if (r.bvalid && s_axi_bready_i)
         n.bvalid = 1'b0;

      // read answer registered on the same edge that takes the address
      if (r.rvalid && s_axi_rready_i)
         n.rvalid = 1'b0;
      if (s_axi_arvalid_i && s_axi_arready_o)
      begin
         n.rvalid = 1'b1;
         n.rresp  = RESP_OKAY;
         n.rdata  = 32'h0000_0000;
         if (reg_hit(s_axi_araddr_i, CTRL_OFS))
            n.rdata[CTRL_I2C_BIT] = r.i2c;
         else if (reg_hit(s_axi_araddr_i, STATUS_OFS))
            n.rdata = status_w;
         else
            n.rresp = RESP_SLVERR;
      end

      // sequencer steps
      case (r.st)
         Q_IDLE:
            n.st = Q_IDLE;
         Q_PWR_WAIT:
            if (t_expired)
            begin
               n.step = r.i2c ? ACT_WRITES : 3'h0;
               n.st   = Q_XFER;
            end
         Q_XFER:
         begin
            n.xstart = 1'b1;
            n.st     = Q_XWAIT;
         end
         Q_XWAIT:
            if (eng_done)
            begin
               if (eng_fail)
               begin
                  n.fail = 1'b1;
                  n.st   = Q_IDLE;
               end
               else if (r.step == LAST_STEP)
               begin
                  n.init_done = 1'b1;
                  n.done      = 1'b1;
                  n.st        = Q_IDLE;
               end
               else
               begin
                  n.step = r.step + 3'h1;
                  n.st   = Q_XFER;
               end
            end
         Q_RST_LOW:
            if (t_expired)
            begin
               n.rst_low = 1'b0;
               n.done    = 1'b1;
               n.st      = Q_IDLE;
            end
         default:
            n.st = Q_IDLE;
      endcase

      // a write completes once both halves are in; commands act only when idle
      if (n.aw_got && n.w_got && !r.bvalid)
      begin
         n.aw_got = 1'b0;
         n.w_got  = 1'b0;
         n.bvalid = 1'b1;
         n.bresp  = RESP_OKAY;
         if (reg_hit(n.aw_addr, CTRL_OFS))
         begin
            if (n.w_strb[1] && r.st == Q_IDLE)
               n.i2c = n.w_data[CTRL_I2C_BIT];
            if (n.w_strb[0] && idle_ok)
            begin
               if (n.w_data[CTRL_RESET_BIT])
               begin
                  n.rst_low   = 1'b1;
                  n.tload     = 1'b1;
                  n.init_done = 1'b0;
                  n.done      = 1'b0;
                  n.fail      = 1'b0;
                  n.st        = Q_RST_LOW;
               end
               else if (n.w_data[CTRL_NORMAL_BIT])
               begin
                  n.pm_normal = 1'b1;
                  n.tload     = 1'b1;
                  n.init_done = 1'b0;
                  n.done      = 1'b0;
                  n.fail      = 1'b0;
                  n.st        = Q_PWR_WAIT;
               end
               else if (n.w_data[CTRL_SLEEP_BIT])
               begin
                  n.pm_normal = 1'b0;
                  n.init_done = 1'b0;
                  n.done      = 1'b1;
                  n.fail      = 1'b0;
               end
            end
         end
         else if (!reg_hit(n.aw_addr, STATUS_OFS))
            n.bresp = RESP_SLVERR;
      end
   end

   // the sleep code is what the ic expects after power-up
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         r    <= '0;
         r.st <= Q_IDLE;
      end
      else
         r <= n;
   end

   ////////////////////////////////////////////////////////////////////////////
   // helpers: delay timer and serial engine

   // the load is registered, so r.st already names the wait being timed
   assign t_cycles = (r.st == Q_RST_LOW) ? CNT_W'(RESET_LOW_CYCLES) : CNT_W'(POWER_UP_CYCLES);

   delay_counter #(
      .CNT_W     (CNT_W)
   ) u_delay (
      .mclk_i    (mclk_i),
      .srst_i    (srst_i),
      .load_i    (r.tload),
      .cycles_i  (t_cycles),
      .expired_o (t_expired)
   );

   serial_write_engine #(
      .HALF_CYC (SER_HALF)
   ) u_serial (
      .mclk_i   (mclk_i),
      .srst_i   (srst_i),
      .start_i  (r.xstart),
      .i2c_i    (r.i2c),
      .addr_i   (frame.addr),
      .data_i   (frame.data),
      .nbytes_i (frame.nbytes),
      .busy_o   (),
      .done_o   (eng_done),
      .fail_o   (eng_fail),
      .sclk_o   (eng_sclk),
      .dout_o   (eng_dout),
      .cs_n_o   (eng_cs_n),
      .sda_i    (i2c_sda_i)
   );

   ////////////////////////////////////////////////////////////////////////////
   // pins toward the ic; takeover lets them all float high

   assign power_mode_select_a_o = r.take | (r.pm_normal ? PM_NORMAL[0] : PM_SLEEP[0]);
   assign power_mode_select_b_o = r.take | (r.pm_normal ? PM_NORMAL[1] : PM_SLEEP[1]);
   assign ic_reset_n_o          = r.take | ~r.rst_low;
   assign spi_cs_n_o            = r.take | r.i2c | eng_cs_n;
   assign spi_sclk_o            = r.take | r.i2c | eng_sclk;
   assign spi_mosi_o            = r.take | r.i2c | eng_dout;
   assign i2c_scl_o             = 1'b0;
   assign i2c_sda_o             = 1'b0;
   // open drain: only pull low, never while in takeover or spi wiring
   assign i2c_scl_oe_o          = !r.take && r.i2c && !eng_sclk;
   assign i2c_sda_oe_o          = !r.take && r.i2c && !eng_dout;

   assign s_axi_bvalid_o        = r.bvalid;
   assign s_axi_bresp_o         = r.bresp;
   assign s_axi_rvalid_o        = r.rvalid;
   assign s_axi_rdata_o         = r.rdata;
   assign s_axi_rresp_o         = r.rresp;

endmodule : meter_init_ctrl

// >>> logic/meter_init_pkg.sv
// constants shared by the metering-ic start-up controller and its helpers
package meter_init_pkg;

   // clock and timing in their own units, cycle counts derived from them
   localparam int          CLK_MHZ         = 200;
   localparam int          POWERUP_WAIT_MS = 50;
   localparam int          RESET_LOW_MS    = 20;
   localparam int unsigned POWERUP_CYC     = POWERUP_WAIT_MS * CLK_MHZ * 1000;
   localparam int unsigned RESET_CYC       = RESET_LOW_MS * CLK_MHZ * 1000;
   localparam int          SER_HALF_CYC    = 50;       // half serial clock period

   // software register map, byte offsets on the axi4-lite port
   localparam logic [7:0]  CTRL_OFS        = 8'h00;
   localparam logic [7:0]  STATUS_OFS      = 8'h04;

   // ctrl fields
   localparam int          CTRL_NORMAL_BIT = 0;        // write one: enter normal mode
   localparam int          CTRL_SLEEP_BIT  = 1;        // write one: enter sleep mode
   localparam int          CTRL_RESET_BIT  = 2;        // write one: pulse ic reset
   localparam int          CTRL_I2C_BIT    = 8;        // wired interface is i2c

   // status fields
   localparam int          ST_BUSY_BIT     = 0;
   localparam int          ST_DONE_BIT     = 1;
   localparam int          ST_FAIL_BIT     = 2;
   localparam int          ST_NORMAL_BIT   = 3;
   localparam int          ST_INIT_BIT     = 4;
   localparam int          ST_TAKE_BIT     = 5;
   localparam int          ST_STEP_LSB     = 8;

   // axi responses
   localparam logic [1:0]  RESP_OKAY       = 2'b00;
   localparam logic [1:0]  RESP_SLVERR     = 2'b10;

   // power-mode pin encodings as {select_b, select_a}
   localparam logic [1:0]  PM_NORMAL       = 2'b01;
   localparam logic [1:0]  PM_SLEEP        = 2'b11;

   // metering-ic side of the start-up sequence
   localparam logic [15:0] PORT_ACT_ADDR   = 16'hEBFF;
   localparam logic [2:0]  ACT_WRITES      = 3'h3;
   localparam logic [2:0]  LAST_STEP       = 3'h5;
   localparam logic [15:0] SEC_CFG_ADDR    = 16'h0100;
   localparam logic [15:0] INTCOEF_ADDR    = 16'h0104;
   localparam logic [15:0] RUN_ADDR        = 16'h0108;
   localparam int          PORT_LOCK_BIT   = 1;
   localparam logic [31:0] PORT_LOCK_VAL   = 32'h0000_0002;
   localparam logic [31:0] INTCOEF_VAL     = 32'h00FF_8000;
   localparam logic [31:0] RUN_VAL         = 32'h0000_0001;
   localparam logic [7:0]  SPI_WRITE_CMD   = 8'h00;
   localparam logic [7:0]  I2C_WRITE_ADDR  = 8'hA0;

endpackage : meter_init_pkg

// >>> logic/serial_write_engine.sv
// write-only serial frame engine: spi (mode 3) or i2c with ack check
module serial_write_engine
   import meter_init_pkg::*;
#(
   parameter int HALF_CYC = SER_HALF_CYC
)
(
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        srst_i,
   // request
   input  wire logic        start_i,
   input  wire logic        i2c_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [31:0] data_i,
   input  wire logic [2:0]  nbytes_i,
   output logic             busy_o,
   output logic             done_o,
   output logic             fail_o,
   // line
   output logic             sclk_o,
   output logic             dout_o,
   output logic             cs_n_o,
   input  wire logic        sda_i
);

   typedef enum logic [2:0] {E_IDLE, E_START, E_LO, E_HI, E_STOP, E_END} eng_e;

   typedef struct packed {
      eng_e        st;
      logic [15:0] cnt;
      logic [55:0] sh;
      logic [2:0]  bitc;
      logic [2:0]  left;
      logic        i2c;
      logic        ack;
      logic        nack;
      logic        sclk;
      logic        dout;
      logic        cs_n;
      logic        done;
      logic        fail;
   } eng_s;

   eng_s        r, n;
   logic        tick;
   logic        byte_end;
   logic [31:0] data_al;

   if (HALF_CYC < 1 || HALF_CYC > 65535) $error("serial_write_engine: bad HALF_CYC");

   // data bytes are left-aligned so that the frame always starts at bit 55
   assign data_al = data_i << {3'(3'h4 - nbytes_i), 3'b000};
   assign tick    = (r.cnt == 16'(HALF_CYC - 1));

   // clock idles high for both buses, data moves in the low half
   always_comb
   begin
      n        = r;
      n.done   = 1'b0;
      n.fail   = 1'b0;
      byte_end = 1'b0;
      if (r.st != E_IDLE)
         n.cnt = tick ? 16'h0000 : r.cnt + 16'h0001;
      case (r.st)
         E_IDLE:
            if (start_i)
            begin
               n.st   = E_START;
               n.cnt  = 16'h0000;
               n.sh   = {(i2c_i ? I2C_WRITE_ADDR : SPI_WRITE_CMD), addr_i, data_al};
               n.left = 3'(nbytes_i + 3'h3);
               n.bitc = 3'h0;
               n.i2c  = i2c_i;
               n.ack  = 1'b0;
               n.nack = 1'b0;
               n.cs_n = i2c_i;          // spi select falls a half period early
               n.dout = ~i2c_i;         // i2c start: data falls while clock high
            end
         E_START:
            if (tick)
            begin
               n.sclk = 1'b0;
               n.dout = r.sh[55];
               n.st   = E_LO;
            end
         E_LO:
            if (tick)
            begin
               n.sclk = 1'b1;
               n.st   = E_HI;
            end
         E_HI:
            if (tick)
            begin
               if (r.ack)
               begin
                  n.nack   = r.nack | sda_i;   // released data line means no ack
                  n.ack    = 1'b0;
                  byte_end = 1'b1;
               end
               else
               begin
                  n.sh   = {r.sh[54:0], 1'b0};
                  n.bitc = r.bitc + 3'h1;
                  if (r.bitc == 3'h7)
                  begin
                     n.ack    = r.i2c;
                     byte_end = ~r.i2c;
                  end
               end
               n.sclk = 1'b0;
               if (byte_end && r.left == 3'h1)
               begin
                  n.sclk = ~r.i2c;      // spi clock stays high: no extra rising edge
                  n.dout = 1'b0;
                  n.st   = E_STOP;
               end
               else
               begin
                  n.dout = n.ack ? 1'b1 : n.sh[55];
                  n.st   = E_LO;
                  if (byte_end)
                     n.left = r.left - 3'h1;
               end
            end
         E_STOP:
            if (tick)
            begin
               n.sclk = 1'b1;
               n.st   = E_END;
            end
         E_END:
            if (tick)
            begin
               n.dout = 1'b1;           // i2c stop: data rises while clock high
               n.cs_n = 1'b1;
               n.done = 1'b1;
               n.fail = r.nack;
               n.st   = E_IDLE;
            end
         default:
            n.st = E_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         r      <= '0;
         r.st   <= E_IDLE;
         r.sclk <= 1'b1;
         r.dout <= 1'b1;
         r.cs_n <= 1'b1;
      end
      else
         r <= n;
   end

   assign busy_o = (r.st != E_IDLE);
   assign done_o = r.done;
   assign fail_o = r.fail;
   assign sclk_o = r.sclk;
   assign dout_o = r.dout;
   assign cs_n_o = r.cs_n;

endmodule : serial_write_engine

// >>> verif/meter_ic_model.sv
// behavioural metering ic: power mode, spi frame capture, i2c acknowledge
module meter_ic_model
   import meter_init_pkg::*;
(
   // controller pins and bench control
   input  wire logic   sel_a_i, sel_b_i, cs_n_i, sclk_i, mosi_i, sda_oe_i, nack_i,
   // wire level and observation
   output logic        sda_o,
   output logic [7:0]  frames_o = 8'h00,
   output logic [39:0] last_o = 40'h0
);
   logic [1:0] mode_r = PM_SLEEP;
   //////////////////////////////////////////////////////////////////////
   // wakes asleep, then follows the pins
   always @(sel_a_i, sel_b_i)
      mode_r = {sel_b_i, sel_a_i};
   // pull-up wins when nobody pulls; a sleeping ic never acks
   assign sda_o = !(sda_oe_i || (mode_r == PM_NORMAL && !nack_i));
   // mode 3: bits are stable at the rising clock
   always @(posedge sclk_i)
      if (!cs_n_i)
         last_o <= {last_o[38:0], mosi_i};
   always @(negedge cs_n_i)
      frames_o <= frames_o + 8'h01;
endmodule : meter_ic_model

// >>> verif/meter_init_ctrl_checker.sv
// pin-level assertions for the metering-ic start-up controller
module meter_init_ctrl_checker
   import meter_init_pkg::*;
(
   input wire logic mclk_i, srst_i, takeover_select_input_i, ic_reset_n_o,
   input wire logic power_mode_select_a_o, power_mode_select_b_o,
   input wire logic spi_cs_n_o, spi_sclk_o, spi_mosi_o, i2c_scl_oe_o, i2c_sda_oe_o
);
   logic take_r;
   logic live_r;
   //////////////////////////////////////////////////////////////////////
   // strap copy taken at the first edge after reset only
   always_ff @(posedge mclk_i)
   begin
      live_r <= !srst_i;
      take_r <= srst_i ? 1'b0 : (live_r ? take_r : takeover_select_input_i);
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   //////////////////////////////////////////////////////////////////////
   sleep_reset_a: assert property ($fell(srst_i) |-> power_mode_select_a_o &&
      power_mode_select_b_o && ic_reset_n_o) else $error("not asleep after reset");
   mode_legal_a: assert property (power_mode_select_a_o)
      else $error("reduced power mode selected");
   wait_first_a: assert property ($fell(power_mode_select_b_o) |->
      (spi_cs_n_o && !i2c_scl_oe_o)[*8]) else $error("transfer before wait");
   sleep_quiet_a: assert property (power_mode_select_b_o |->
      spi_cs_n_o && !i2c_scl_oe_o) else $error("transfer while asleep");
   spi_idle_a: assert property (spi_cs_n_o |-> spi_sclk_o)
      else $error("serial clock low outside frame");
   reset_low_a: assert property ($fell(ic_reset_n_o) |->
      (!ic_reset_n_o)[*8] ##[1:20] ic_reset_n_o) else $error("reset pulse length");
   reset_quiet_a: assert property (!ic_reset_n_o |->
      spi_cs_n_o && !i2c_scl_oe_o) else $error("transfer during ic reset");
   take_high_a: assert property (take_r |-> power_mode_select_a_o &&
      power_mode_select_b_o && ic_reset_n_o && spi_cs_n_o && spi_sclk_o && spi_mosi_o
      && !i2c_scl_oe_o && !i2c_sda_oe_o) else $error("pins not released");
   cover property ($fell(spi_cs_n_o));
   cover property ($rose(i2c_sda_oe_o));
   cover property ($fell(ic_reset_n_o));
endmodule : meter_init_ctrl_checker

bind meter_init_ctrl meter_init_ctrl_checker i_chk (.*);

// >>> verif/tb_meter_init_ctrl.sv
// self-checking bench for the metering-ic start-up controller
module tb_meter_init_ctrl
   import meter_init_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 1'b0, srst_i = 1'b1, takeover_select_input_i = 1'b0, nack = 1'b0;
   logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
   logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
   logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00, f;
   logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rdat;
   logic [3:0] s_axi_wstrb_i = 4'hF;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp;
   logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   logic power_mode_select_a_o, power_mode_select_b_o, ic_reset_n_o, spi_cs_n_o;
   logic spi_sclk_o, spi_mosi_o, i2c_scl_o, i2c_scl_oe_o, i2c_sda_o, i2c_sda_oe_o, i2c_sda_i;
   logic [7:0] frames;
   logic [39:0] last, lastf [8];
   int err_count = 0, comparisons = 0, lowcnt = 0;
   //////////////////////////////////////////////////////////////////////
   // short waits keep the run small; expectations use the same numbers
   meter_init_ctrl #(.POWER_UP_CYCLES(20), .RESET_LOW_CYCLES(10), .SER_HALF(2)) i_dut (.*);
   meter_ic_model i_ic (.sel_a_i(power_mode_select_a_o), .sel_b_i(power_mode_select_b_o),
      .cs_n_i(spi_cs_n_o), .sclk_i(spi_sclk_o), .mosi_i(spi_mosi_o), .sda_oe_i(i2c_sda_oe_o),
      .nack_i(nack), .sda_o(i2c_sda_i), .frames_o(frames), .last_o(last));
   always #2.5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) if (!ic_reset_n_o) lowcnt++;
   // snapshot of the ic shift register as each spi frame closes
   always @(posedge spi_cs_n_o) lastf[frames[2:0]] = last;
   //////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [39:0] got, input logic [39:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // one axi4-lite access; each valid drops at its own handshake
   task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      s_axi_awaddr_i <= a;
      s_axi_araddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= wr;
      s_axi_wvalid_i <= wr;
      s_axi_bready_i <= wr;
      s_axi_arvalid_i <= !wr;
      s_axi_rready_i <= !wr;
      do
      begin
         @(posedge mclk_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      end while (!(s_axi_bvalid_o || s_axi_rvalid_o));
      rsp = wr ? s_axi_bresp_o : s_axi_rresp_o;
      rdat = s_axi_rdata_o;
      s_axi_bready_i <= 1'b0;
      s_axi_rready_i <= 1'b0;
   endtask : bus
   task automatic idle;
      do bus(1'b0, STATUS_OFS, 32'h0); while (rdat[ST_BUSY_BIT] !== 1'b0);
   endtask : idle
   // strap flips after it was sampled, so a late change must go unseen
   task automatic rst(input logic t);
      srst_i <= 1'b1;
      takeover_select_input_i <= t;
      repeat (12) @(posedge mclk_i);
      srst_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      takeover_select_input_i <= ~t;
   endtask : rst
   task automatic conclude;
      $display("comparisons %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude
   //////////////////////////////////////////////////////////////////////
   initial
   begin
      rst(1'b0);
      chk("mode", {power_mode_select_b_o, power_mode_select_a_o}, PM_SLEEP);
      bus(1'b0, STATUS_OFS, 32'h0);
      chk("status", rdat[5:0], 6'h00);
      chk("rresp", rsp, RESP_OKAY);
      bus(1'b1, 8'h08, 32'h1);
      chk("unmapped", rsp, RESP_SLVERR);
      f = frames;
      bus(1'b1, CTRL_OFS, 32'h1);
      bus(1'b1, CTRL_OFS, 32'h2);
      idle;
      chk("status", rdat[5:0], 6'h1A);
      chk("frames", frames - f, 8'h06);
      chk("run", last, 40'h00_0108_0001);
      chk("lock", lastf[f[2:0] + 3'h4], 40'h00_0001_0002);
      chk("coef", lastf[f[2:0] + 3'h5], 40'h04_00FF_8000);
      bus(1'b1, CTRL_OFS, 32'h2);
      chk("mode", {power_mode_select_b_o, power_mode_select_a_o}, PM_SLEEP);
      nack <= 1'b1;
      bus(1'b1, CTRL_OFS, 32'h101);
      idle;
      chk("status", rdat[5:0], 6'h0C);
      bus(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl", rdat, 32'h100);
      nack <= 1'b0;
      f = frames;
      bus(1'b1, CTRL_OFS, 32'h101);
      idle;
      chk("status", rdat[5:0], 6'h1A);
      chk("frames", frames - f, 8'h00);
      lowcnt = 0;
      bus(1'b1, CTRL_OFS, 32'h4);
      idle;
      chk("done", rdat[ST_DONE_BIT], 1'b1);
      chk("low", lowcnt, 11);
      rst(1'b1);
      bus(1'b1, CTRL_OFS, 32'h1);
      bus(1'b0, STATUS_OFS, 32'h0);
      chk("status", rdat[5:0], 6'h20);
      chk("pins", {power_mode_select_b_o, power_mode_select_a_o, ic_reset_n_o, spi_cs_n_o,
         spi_sclk_o, spi_mosi_o, i2c_scl_oe_o, i2c_sda_oe_o}, 8'hFC);
      conclude;
   end
   // watchdog well beyond the few thousand cycles the tests need
   initial
   begin
      #200000;
      err_count++;
      conclude;
   end
endmodule : tb_meter_init_ctrl
